// file: core/bpsc_top.sv
/*
  Backlight PWM source control: register file, PWM source selection,
  pin duty measurement, light sensor counting, slope ramp and PWM output.
  Assumes the serial bus decoder outside presents one-cycle read and write
  strobes, and that the nonvolatile store presents its bytes as a struct.
*/
`timescale 1ns/10ps
module bpsc_top #(
  parameter int OFF_CYC     = bpsc_pkg::OFF_CYC,
  parameter int ALS_WIN_CYC = bpsc_pkg::ALS_WIN_CYC,
  parameter int SLOPE0_CYC  = bpsc_pkg::SLOPE0_CYC,
  parameter int SLOPE1_CYC  = bpsc_pkg::SLOPE1_CYC,
  parameter int SLOPE2_CYC  = bpsc_pkg::SLOPE2_CYC,
  parameter int SLOPE3_CYC  = bpsc_pkg::SLOPE3_CYC
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                en_pin,
  input  wire logic                pwm_pin,
  input  wire logic                sensor_in,
  input  wire bpsc_pkg::bpsc_nvm_t nvm,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  output logic [6:0]               string_on,
  output logic [7:0]               main_current,
  output logic [7:0]               sub_current,
  output logic                     sensor_en_out,
  output logic                     active
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                          loaded;
    logic [7:0]                    def_main;
    logic [7:0]                    def_sub;
    logic                          cfg_mode;
    logic                          cfg_sel;
    logic                          sensor_en;
    logic                          cur_sel;
    logic                          light_use;
    logic [7:0]                    string_force_on;
    logic [7:0]                    main_cur;
    logic [7:0]                    sub_cur;
    logic [7:0]                    main_bri;
    logic [7:0]                    sub_bri;
    logic [7:0]                    light_snap;
    logic                          pin_q;
    logic [bpsc_pkg::PER_W-1:0]    per_cnt;
    logic [bpsc_pkg::PER_W-1:0]    hi_cnt;
    logic [bpsc_pkg::PER_W-1:0]    hi_last;
    logic [bpsc_pkg::PER_W-1:0]    per_last;
    logic [9:0]                    duty;
    logic [bpsc_pkg::IDLE_W-1:0]   idle;
    logic [bpsc_pkg::WIN_W-1:0]    win;
    logic [bpsc_pkg::ALS_W-1:0]    edges;
    logic                          sens_q;
    logic [9:0]                    light_res;
    logic [bpsc_pkg::RAMP_W-1:0]   ramp_cnt;
    logic [9:0]                    level;
    logic [7:0]                    step_cnt;
    logic [9:0]                    pwm_cnt;
    logic [9:0]                    main_lat;
    logic [9:0]                    sub_lat;
    logic [7:0]                    rdata;
    logic [6:0]                    str;
    logic [7:0]                    main_out;
    logic [7:0]                    sub_out;
    logic                          sens_out;
    logic                          active;
  } bpsc_state_t;

  bpsc_state_t q, d;

  logic                solo;
  bpsc_pkg::bpsc_src_t src;
  logic                duty_go;
  logic                duty_done;
  logic [9:0]          duty_res;
  logic                light_go;
  logic                light_done;
  logic [9:0]          light_q;
  logic [9:0]          bri_y;
  logic [9:0]          light_y;
  logic [19:0]         mix;
  logic [19:0]         lit;
  logic [9:0]          target;
  logic [bpsc_pkg::RAMP_W-1:0] ramp_lim;
  logic                rise;
  logic                fall;
  logic                act;
  logic [6:0]          str_n;
  logic                main_on;
  logic                sub_on;
  logic [7:0]          rd;

  assign solo = nvm.solo_cfg[bpsc_pkg::SOLO_BIT];

  // ------------------------------------------------------------------
  // arithmetic helpers
  // ------------------------------------------------------------------
  bpsc_curve u_bri_curve (
    .x    ({q.main_bri, 2'h0}),
    .coef (nvm.bri_curve),
    .y    (bri_y)
  );

  bpsc_curve u_light_curve (
    .x    (q.light_res),
    .coef (nvm.light_curve),
    .y    (light_y)
  );

  bpsc_div #(
    .NUM_W (bpsc_pkg::PER_W + bpsc_pkg::PWM_W),
    .DEN_W (bpsc_pkg::PER_W),
    .Q_W   (bpsc_pkg::PWM_W)
  ) u_duty_div (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (duty_go),
    .num     ({q.hi_last, 10'h000}),
    .den     (q.per_last),
    .done    (duty_done),
    .q       (duty_res)
  );

  bpsc_div #(
    .NUM_W (bpsc_pkg::ALS_W),
    .DEN_W (bpsc_pkg::PWM_W),
    .Q_W   (bpsc_pkg::PWM_W)
  ) u_light_div (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (light_go),
    .num     (q.edges),
    .den     (nvm.prescale),
    .done    (light_done),
    .q       (light_q)
  );

  // ------------------------------------------------------------------
  // per-string output selection
  // ------------------------------------------------------------------
  assign main_on = q.pwm_cnt < q.main_lat;
  assign sub_on  = q.pwm_cnt < q.sub_lat;

  for (genvar i = 0; i < bpsc_pkg::NUM_STRINGS; i++) begin : g_str
    always_comb begin
      if (!act) begin
        str_n[i] = 1'b0;
      end else if (q.string_force_on[i]) begin
        str_n[i] = 1'b1;
      end else if (i == bpsc_pkg::SUB_STRING &&
                   nvm.string_group_config != bpsc_pkg::CONF_ALL_MAIN) begin
        str_n[i] = sub_on;
      end else if (i < bpsc_pkg::MIN_MAIN_STRINGS + int'(nvm.string_group_config)) begin
        str_n[i] = (src == bpsc_pkg::SRC_DIRECT) ? pwm_pin : main_on;
      end else begin
        str_n[i] = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d        = q;
    duty_go  = 1'b0;
    light_go = 1'b0;
    rd       = bpsc_pkg::UNMAPPED_READ;
    src      = solo ? bpsc_pkg::SRC_DUTY
                    : bpsc_pkg::bpsc_src_t'({q.cfg_mode, q.cfg_sel});

    if (!q.loaded) begin
      d.loaded   = 1'b1;
      d.def_main = nvm.main_def_cur;
      d.def_sub  = nvm.sub_def_cur;
    end

    // register writes are shut out in stand-alone operation
    if (reg_wr && !solo) begin
      case (reg_addr)
        bpsc_pkg::FIRST_CONFIG_OFS: begin
          d.cfg_sel  = reg_wdata[bpsc_pkg::CFG1_SEL_BIT];
          d.cfg_mode = reg_wdata[bpsc_pkg::CFG1_MODE_BIT];
        end
        bpsc_pkg::SECOND_CONFIG_OFS: begin
          d.sensor_en = reg_wdata[bpsc_pkg::CFG2_SENSOR_BIT];
          d.cur_sel   = reg_wdata[bpsc_pkg::CFG2_CUR_SEL_BIT];
          d.light_use = reg_wdata[bpsc_pkg::CFG2_LIGHT_BIT];
        end
        bpsc_pkg::DIRECT_CONTROL_OFS:    d.string_force_on = reg_wdata;
        bpsc_pkg::MAIN_GROUP_CURRENT_OFS: d.main_cur = reg_wdata;
        bpsc_pkg::SUB_GROUP_CURRENT_OFS:  d.sub_cur  = reg_wdata;
        bpsc_pkg::MAIN_GROUP_BRIGHT_OFS:  d.main_bri = reg_wdata;
        bpsc_pkg::SUB_GROUP_BRIGHT_OFS:   d.sub_bri  = reg_wdata;
        default: ;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        bpsc_pkg::FIRST_CONFIG_OFS: begin
          rd[bpsc_pkg::CFG1_SEL_BIT]  = q.cfg_sel;
          rd[bpsc_pkg::CFG1_MODE_BIT] = q.cfg_mode;
        end
        bpsc_pkg::SECOND_CONFIG_OFS: begin
          rd[bpsc_pkg::CFG2_SENSOR_BIT]  = q.sensor_en;
          rd[bpsc_pkg::CFG2_CUR_SEL_BIT] = q.cur_sel;
          rd[bpsc_pkg::CFG2_LIGHT_BIT]   = q.light_use;
        end
        bpsc_pkg::DIRECT_CONTROL_OFS:     rd = q.string_force_on;
        bpsc_pkg::MAIN_GROUP_CURRENT_OFS: rd = q.main_cur;
        bpsc_pkg::SUB_GROUP_CURRENT_OFS:  rd = q.sub_cur;
        bpsc_pkg::MAIN_GROUP_BRIGHT_OFS:  rd = q.main_bri;
        bpsc_pkg::SUB_GROUP_BRIGHT_OFS:   rd = q.sub_bri;
        bpsc_pkg::LIGHT_RESULT_HIGH_OFS: begin
          rd           = {6'h00, q.light_res[9:8]};
          // low half frozen so the pair always belongs to one measurement
          d.light_snap = q.light_res[7:0];
        end
        bpsc_pkg::LIGHT_RESULT_LOW_OFS:   rd = q.light_snap;
        default: ;
      endcase
      d.rdata = rd;
    end

    // pin duty measurement, one division per input period
    d.pin_q = pwm_pin;
    rise    = pwm_pin && !q.pin_q;
    fall    = !pwm_pin && q.pin_q;
    if (rise) begin
      duty_go    = q.per_cnt != '0;
      d.hi_last  = q.hi_cnt;
      d.per_last = q.per_cnt;
      d.per_cnt  = bpsc_pkg::PER_W'(1);
      d.hi_cnt   = bpsc_pkg::PER_W'(1);
    end else if (q.per_cnt != '1) begin
      d.per_cnt = q.per_cnt + bpsc_pkg::PER_W'(1);
      d.hi_cnt  = q.hi_cnt + (pwm_pin ? bpsc_pkg::PER_W'(1) : bpsc_pkg::PER_W'(0));
    end else begin
      // no edge for longer than the slowest legal input: pin is static
      d.duty = pwm_pin ? bpsc_pkg::DUTY_FULL : 10'h000;
    end
    if (duty_done) begin
      d.duty = duty_res;
    end

    // activity watch for stand-alone shutdown
    if (en_pin && (rise || fall)) begin
      d.idle = '0;
    end else if (q.idle < bpsc_pkg::IDLE_W'(OFF_CYC)) begin
      d.idle = q.idle + bpsc_pkg::IDLE_W'(1);
    end
    act = solo ? (en_pin && q.idle < bpsc_pkg::IDLE_W'(OFF_CYC)) : en_pin;
    d.active = act;

    // light sensor frequency count over a fixed window
    d.sens_q = sensor_in;
    if (q.sensor_en) begin
      if (q.win >= bpsc_pkg::WIN_W'(ALS_WIN_CYC - 1)) begin
        light_go = 1'b1;
        d.win    = '0;
        d.edges  = '0;
      end else begin
        d.win = q.win + bpsc_pkg::WIN_W'(1);
        if (sensor_in && !q.sens_q && q.edges != '1) begin
          d.edges = q.edges + bpsc_pkg::ALS_W'(1);
        end
      end
    end else begin
      d.win   = '0;
      d.edges = '0;
    end
    if (light_done) begin
      d.light_res = light_q;
    end

    // target brightness from the chosen source
    mix = bri_y * q.duty;
    case (src)
      bpsc_pkg::SRC_DUTY:     target = q.duty;
      bpsc_pkg::SRC_BRIGHT:   target = bri_y;
      bpsc_pkg::SRC_COMBINED: target = mix[19:10];
      default:                target = q.duty;
    endcase
    lit = target * light_y;
    if (q.light_use && !solo) begin
      target = lit[19:10];
    end

    // slope ramp, one code per tick
    case (nvm.slope_sel)
      2'h0:    ramp_lim = bpsc_pkg::RAMP_W'(SLOPE0_CYC);
      2'h1:    ramp_lim = bpsc_pkg::RAMP_W'(SLOPE1_CYC);
      2'h2:    ramp_lim = bpsc_pkg::RAMP_W'(SLOPE2_CYC);
      default: ramp_lim = bpsc_pkg::RAMP_W'(SLOPE3_CYC);
    endcase
    if (q.ramp_cnt + bpsc_pkg::RAMP_W'(1) >= ramp_lim) begin
      d.ramp_cnt = '0;
      if (q.level < target) begin
        d.level = q.level + 10'h001;
      end else if (q.level > target) begin
        d.level = q.level - 10'h001;
      end
    end else begin
      d.ramp_cnt = q.ramp_cnt + bpsc_pkg::RAMP_W'(1);
    end

    // output PWM period from the stored divider, not from the pin
    if (q.step_cnt >= nvm.pwm_div) begin
      d.step_cnt = 8'h00;
      d.pwm_cnt  = q.pwm_cnt + 10'h001;
      if (q.pwm_cnt == bpsc_pkg::DUTY_FULL) begin
        d.main_lat = q.level;
        d.sub_lat  = {q.sub_bri, 2'h0};
      end
    end else begin
      d.step_cnt = q.step_cnt + 8'h01;
    end

    d.str = str_n;
    if (solo || !q.cur_sel) begin
      d.main_out = q.def_main;
      d.sub_out  = q.def_sub;
    end else begin
      d.main_out = q.main_cur;
      d.sub_out  = q.sub_cur;
    end
    d.sens_out = nvm.sensor_active_high ? q.sensor_en : !q.sensor_en;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q          <= '0;
      q.cfg_sel  <= bpsc_pkg::CFG1_RESET[bpsc_pkg::CFG1_SEL_BIT];
      q.cfg_mode <= bpsc_pkg::CFG1_RESET[bpsc_pkg::CFG1_MODE_BIT];
      q.per_cnt  <= '1;
      q.idle     <= '1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata     = q.rdata;
  assign string_on     = q.str;
  assign main_current  = q.main_out;
  assign sub_current   = q.sub_out;
  assign sensor_en_out = q.sens_out;
  assign active        = q.active;
endmodule : bpsc_top

// file: common/bpsc_pkg.sv
/*
  Shared constants and types for the backlight PWM source control block.
  Assumes a 40 MHz core clock and a nonvolatile store that presents its
  contents as a stable struct once the device is powered.
*/
package bpsc_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] MAIN_GROUP_CURRENT_OFS  = 8'h05;
  localparam logic [7:0] SUB_GROUP_CURRENT_OFS   = 8'h06;
  localparam logic [7:0] FIRST_CONFIG_OFS        = 8'h01;
  localparam logic [7:0] SECOND_CONFIG_OFS       = 8'h02;
  localparam logic [7:0] DIRECT_CONTROL_OFS      = 8'h03;
  localparam logic [7:0] MAIN_GROUP_BRIGHT_OFS   = 8'h07;
  localparam logic [7:0] SUB_GROUP_BRIGHT_OFS    = 8'h08;
  localparam logic [7:0] LIGHT_RESULT_HIGH_OFS   = 8'h09;
  localparam logic [7:0] LIGHT_RESULT_LOW_OFS    = 8'h0A;
  localparam logic [7:0] MAIN_DEFAULT_CUR_NVM    = 8'hB0;
  localparam logic [7:0] SUB_DEFAULT_CUR_NVM     = 8'hB1;
  localparam logic [7:0] STANDALONE_CONFIG_NVM   = 8'hB4;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int         CFG1_SEL_BIT     = 0;
  localparam int         CFG1_MODE_BIT    = 1;
  localparam int         CFG2_SENSOR_BIT  = 0;
  localparam int         CFG2_CUR_SEL_BIT = 1;
  localparam int         CFG2_LIGHT_BIT   = 2;
  localparam int         SOLO_BIT         = 0;
  localparam logic [7:0] CFG1_RESET       = 8'h01;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;
  localparam logic [7:0] FACTORY_CURRENT  = 8'h57;
  localparam int         CURRENT_STEP_UA  = 230;
  localparam int         MIN_MAIN_STRINGS = 4;
  localparam int         NUM_STRINGS      = 7;
  localparam int         SUB_STRING       = 6;
  localparam logic [1:0] CONF_ALL_MAIN    = 2'h3;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int         PWM_W    = 10;
  localparam int         PER_W    = 19;
  localparam int         IDLE_W   = 21;
  localparam int         WIN_W    = 25;
  localparam int         ALS_W    = 24;
  localparam int         RAMP_W   = 17;
  localparam logic [9:0] DUTY_FULL = 10'h3FF;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_KHZ      = 40000;
  localparam int OFF_MS       = 50;
  localparam int ALS_WIN_MS   = 500;
  localparam int SLOPE0_MS    = 130;
  localparam int SLOPE1_MS    = 500;
  localparam int SLOPE2_MS    = 1000;
  localparam int SLOPE3_MS    = 2000;
  localparam int RAMP_STEPS   = 1024;
  localparam int OFF_CYC      = OFF_MS * CLK_KHZ;
  localparam int ALS_WIN_CYC  = ALS_WIN_MS * CLK_KHZ;
  localparam int SLOPE0_CYC   = SLOPE0_MS * CLK_KHZ / RAMP_STEPS;
  localparam int SLOPE1_CYC   = SLOPE1_MS * CLK_KHZ / RAMP_STEPS;
  localparam int SLOPE2_CYC   = SLOPE2_MS * CLK_KHZ / RAMP_STEPS;
  localparam int SLOPE3_CYC   = SLOPE3_MS * CLK_KHZ / RAMP_STEPS;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_COMBINED,
    SRC_DUTY,
    SRC_BRIGHT,
    SRC_DIRECT
  } bpsc_src_t;

  typedef struct packed {
    logic [9:0]       brk1;
    logic [9:0]       brk2;
    logic [2:0][9:0]  base;
    logic [2:0][7:0]  slope;
  } bpsc_curve_t;

  typedef struct packed {
    logic [7:0]  main_def_cur;
    logic [7:0]  sub_def_cur;
    logic [7:0]  solo_cfg;
    logic [1:0]  string_group_config;
    logic        sensor_active_high;
    logic [1:0]  slope_sel;
    logic [7:0]  pwm_div;
    logic [9:0]  prescale;
    bpsc_curve_t bri_curve;
    bpsc_curve_t light_curve;
  } bpsc_nvm_t;

endpackage : bpsc_pkg

// file: core/bpsc_curve.sv
/*
  Three-segment piecewise linear curve, 10-bit in and 10-bit out.
  Assumes break points ascend and coefficients are static while used.
*/
`timescale 1ns/10ps
module bpsc_curve (
  input  wire logic [9:0]           x,
  input  wire bpsc_pkg::bpsc_curve_t coef,
  output logic [9:0]                y
);
  logic [1:0]  seg;
  logic [9:0]  org;
  logic [17:0] prod;
  logic [10:0] sum;

  always_comb begin
    if (x >= coef.brk2) begin
      seg = 2'h2;
      org = coef.brk2;
    end else if (x >= coef.brk1) begin
      seg = 2'h1;
      org = coef.brk1;
    end else begin
      seg = 2'h0;
      org = 10'h000;
    end
    // slope is four fraction bits
    prod = coef.slope[seg] * (x - org);
    sum  = {1'b0, coef.base[seg]} + {1'b0, prod[13:4]};
    // saturate rather than wrap so a steep slope cannot dim at the top
    if (sum[10] || prod[17:14] != 4'h0) begin
      y = bpsc_pkg::DUTY_FULL;
    end else begin
      y = sum[9:0];
    end
  end
endmodule : bpsc_curve

// file: core/bpsc_div.sv
/*
  Iterative restoring divider with a quotient saturated to Q_W bits.
  Assumes start is a pulse and is not repeated while busy.
*/
`timescale 1ns/10ps
module bpsc_div #(
  parameter int NUM_W = 29,
  parameter int DEN_W = 19,
  parameter int Q_W   = 10
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  done,
  output logic [Q_W-1:0]        q
);
  typedef struct packed {
    logic             busy;
    logic [5:0]       cnt;
    logic [NUM_W-1:0] num;
    logic [NUM_W-1:0] rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
    logic             done;
    logic [Q_W-1:0]   q;
  } bpsc_div_t;

  bpsc_div_t s_q, s_d;
  logic [NUM_W-1:0] trial;

  always_comb begin
    s_d    = s_q;
    s_d.done = 1'b0;
    trial  = {s_q.rem[NUM_W-2:0], s_q.num[NUM_W-1]};
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 6'(NUM_W);
      s_d.num  = num;
      s_d.den  = den;
      s_d.rem  = '0;
      s_d.quo  = '0;
    end else if (s_q.busy) begin
      s_d.num = {s_q.num[NUM_W-2:0], 1'b0};
      if (trial >= NUM_W'(s_q.den)) begin
        s_d.rem = trial - NUM_W'(s_q.den);
        s_d.quo = {s_q.quo[NUM_W-2:0], 1'b1};
      end else begin
        s_d.rem = trial;
        s_d.quo = {s_q.quo[NUM_W-2:0], 1'b0};
      end
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        // zero divisor or overflow reads as full scale
        if (s_q.den == '0 || s_d.quo[NUM_W-1:Q_W] != '0) begin
          s_d.q = '1;
        end else begin
          s_d.q = s_d.quo[Q_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign q    = s_q.q;
endmodule : bpsc_div

// file: bench/bpsc_monitor.sv
/*
  Port checker for bpsc_top.
  Assumes one-cycle register strobes and a static store.
*/
`timescale 1ns/10ps
module bpsc_monitor (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                en_pin,
  input wire logic                pwm_pin,
  input wire bpsc_pkg::bpsc_nvm_t nvm,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic [6:0]          string_on,
  input wire logic [7:0]          main_current,
  input wire logic [7:0]          sub_current,
  input wire logic                sensor_en_out,
  input wire logic                active
);
  // shadow registers; writes in stand-alone are dropped, as the device does
  wire logic  we = reg_wr && !nvm.solo_cfg[0];
  logic [1:0] up_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] force_q;
  logic [7:0] cur_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q    <= 2'h0;
      cfg1_q  <= 8'h01;
      cfg2_q  <= 8'h00;
      force_q <= 8'h00;
      cur_q   <= 8'h00;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      if (we && reg_addr == 8'h01) cfg1_q <= reg_wdata;
      if (we && reg_addr == 8'h02) cfg2_q <= reg_wdata;
      if (we && reg_addr == 8'h03) force_q <= reg_wdata;
      if (we && reg_addr == 8'h05) cur_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_active_follow: assert property (up_q[1] && !nvm.solo_cfg[0]
    |-> active == $past(en_pin)) else $error("active off enable pin");
  a_strings_dark: assert property (!active && !$past(active)
    |-> string_on == 7'h00) else $error("strings lit while off");
  a_sensor_level: assert property (up_q[1]
    |-> sensor_en_out == ($past(cfg2_q[0]) ~^ nvm.sensor_active_high))
    else $error("sensor pin level");
  a_current_pick: assert property (up_q == 2'h3
    |-> main_current == ($past(cfg2_q[1]) ? $past(cur_q) : nvm.main_def_cur))
    else $error("main current source");
  a_sub_default: assert property (up_q == 2'h3 && !$past(cfg2_q[1])
    |-> sub_current == nvm.sub_def_cur) else $error("sub current source");
  a_light_high: assert property ($past(reg_rd) && $past(reg_addr) == 8'h09
    |-> reg_rdata[7:2] == 6'h00) else $error("light high byte wide");
  a_force_full: assert property (up_q == 2'h3 && active && $past(active)
    |-> (string_on & $past(force_q[6:0])) == $past(force_q[6:0]))
    else $error("forced string not on");
  a_direct_pass: assert property ($past(cfg1_q[1:0], 2) == 2'h3 && $past(active)
    && $past(cfg1_q[1:0]) == 2'h3 && $past(force_q) == 8'h00
    |-> string_on[3:0] == {4{$past(pwm_pin)}}) else $error("direct pin not followed");
  c_direct: cover property ($past(cfg1_q[1:0]) == 2'h3 && string_on[0]);
  c_solo_off: cover property (nvm.solo_cfg[0] && $fell(active));
  c_light_read: cover property ($past(reg_rd) && $past(reg_addr) == 8'h09);
endmodule : bpsc_monitor

bind bpsc_top bpsc_monitor mon (.*);

// file: bench/bpsc_partner.sv
/*
  Far side: an external PWM source and a light-to-frequency sensor.
  Assumes the bench sets high and low times in clock cycles.
*/
`timescale 1ns/10ps
module bpsc_partner (
  input  wire logic clk,
  input  var int    hi,
  input  var int    lo,
  input  wire logic en,
  output logic      pwm,
  output logic      sens
);
  int n = 0;
  int s = 0;
  initial pwm = 1'b0;
  initial sens = 1'b0;
  always @(posedge clk) begin
    #1;
    n = (n + 1 >= hi + lo) ? 0 : n + 1;
    s = (s + 1) % 10;
    pwm = n < hi;  // period hi+lo, kept in range by the bench
    sens = en && s < 5;  // an unpowered sensor makes no edges
  end
endmodule : bpsc_partner

// file: bench/tb.sv
/*
  Self-checking bench for bpsc_top.
  Assumes scaled counts: 200 off, 500 window, slopes 2..4; slowest slope
  keeps its default since no scenario selects it.
*/
`timescale 1ns/10ps
module tb;
  logic                clk = 0;
  logic                reset_n = 0;
  logic                en_pin = 0;
  logic                reg_wr = 0;
  logic                reg_rd = 0;
  logic [7:0]          reg_addr = 8'h00;
  logic [7:0]          reg_wdata = 8'h00;
  logic [7:0]          d;
  logic [7:0]          reg_rdata, main_current, sub_current;
  logic [6:0]          string_on;
  logic                pwm_pin, sensor_in, sensor_en_out, active;
  bpsc_pkg::bpsc_nvm_t nvm = '0;
  int                  hi = 400;
  int                  lo = 1200;
  int                  failures = 0;
  int                  checks_done = 0;
  int                  cyc = 0;
  always #12.5 clk = ~clk;
  bpsc_top #(.OFF_CYC(200), .ALS_WIN_CYC(500), .SLOPE0_CYC(2), .SLOPE1_CYC(3),
    .SLOPE2_CYC(4)) dut (.*);
  bpsc_partner src (.clk(clk), .hi(hi), .lo(lo), .en(sensor_en_out), .pwm(pwm_pin),
    .sens(sensor_in));
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    tick(1);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    tick(1);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    tick(1);
    reg_rd = 1;
    reg_addr = a;
    tick(1);
    reg_rd = 0;
    tick(1);
    d = reg_rdata;
  endtask : rd
  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic sc_regs;
    rd(8'h01);
    chk("cfg1", 10'h001, {2'h0, d});
    rd(8'h0F);
    chk("unmapped", 10'h000, {2'h0, d});
    chk("cur", {2'h0, 8'((20000 + 115) / 230)}, {2'h0, main_current});
    wr(8'h05, 8'h12);
    tick(3);
    chk("cur", {2'h0, bpsc_pkg::FACTORY_CURRENT}, {2'h0, main_current});
    wr(8'h02, 8'h02);
    tick(3);
    chk("cur", 10'h012, {2'h0, main_current});
    wr(8'h02, 8'h00);
  endtask : sc_regs
  task automatic count_on(output int n, output int m);
    n = 0;
    m = 0;
    repeat (1024) begin
      tick(1);
      n += string_on[0];
      m += string_on[6];
    end
  endtask : count_on
  task automatic sc_duty;
    int n, m;
    tick(6000);
    count_on(n, m);
    chk("duty", 10'(400 * 1024 / 1600), 10'(n));
  endtask : sc_duty
  task automatic sc_bright;
    int n, m;
    hi = 400;
    lo = 1200;
    wr(8'h07, 8'h40);
    wr(8'h08, 8'h40);
    wr(8'h01, 8'h02);
    tick(2000);
    count_on(n, m);
    chk("bright", 10'h100, 10'(n));
    chk("sub", 10'h100, 10'(m));
    wr(8'h01, 8'h00);
    tick(1500);
    count_on(n, m);
    chk("combined", 10'h040, 10'(n));
  endtask : sc_bright
  task automatic sc_light;
    wr(8'h02, 8'h01);
    tick(2);
    chk("sens_en", 10'h001, {9'h0, sensor_en_out});
    tick(1100);
    rd(8'h09);
    chk("light_hi", 10'h000, {2'h0, d});
    rd(8'h0A);
    chk("light_lo", 10'(500 / 10 / 5), {2'h0, d});
    wr(8'h02, 8'h00);
  endtask : sc_light
  task automatic sc_drive;
    wr(8'h03, 8'h7F);
    tick(3);
    chk("force", 10'h07F, {3'h0, string_on});
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h03);
    lo = 0;
    tick(4);
    chk("direct", 10'h03F, {3'h0, string_on});
    hi = 0;
    tick(4);
    chk("direct", 10'h000, {3'h0, string_on});
  endtask : sc_drive
  task automatic sc_solo;
    reset_n = 0;
    nvm.solo_cfg = 8'h01;
    hi = 40;
    lo = 120;
    tick(2);
    reset_n = 1;
    wr(8'h07, 8'h55);
    rd(8'h07);
    chk("solo_wr", 10'h000, {2'h0, d});
    tick(400);
    chk("solo_on", 10'h001, {9'h0, active});
    chk("solo_cur", {2'h0, bpsc_pkg::FACTORY_CURRENT}, {2'h0, main_current});
    hi = 0;
    tick(300);
    chk("solo_off", 10'h000, {9'h0, active});
  endtask : sc_solo
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    nvm.main_def_cur = bpsc_pkg::FACTORY_CURRENT;
    nvm.sub_def_cur = bpsc_pkg::FACTORY_CURRENT;
    nvm.string_group_config = 2'h2;
    nvm.sensor_active_high = 1'b1;
    nvm.prescale = 10'h005;
    nvm.bri_curve.brk1 = 10'h3FF;
    nvm.bri_curve.brk2 = 10'h3FF;
    nvm.bri_curve.slope[0] = 8'h10;
    tick(2);
    reset_n = 1;
    en_pin = 1;
    sc_regs();
    sc_duty();
    sc_light();
    sc_drive();
    sc_bright();
    sc_solo();
    stop_test();
  end
endmodule : tb
